// file: src/rail_power_status_flags.sv
`timescale 1ns/1ps
module rail_power_status_flags
  import rail_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [RAIL_COUNT-1:0] rail_in_regulation_flag_i,
  input wire logic [RAIL_COUNT-1:0] rail_regulation_lost_flag_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  rail_status_if bus ();
  bank_state_t r;
  bank_state_t n;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic load_tx;
  logic wr_en;
  logic [7:0] rd_data;
  logic [7:0] clr_lo;
  logic [FLT_HI_W-1:0] clr_hi;

  rail_input_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .ok_raw_i(rail_in_regulation_flag_i),
    .lost_raw_i(rail_regulation_lost_flag_i),
    .scl_raw_i(scl_i),
    .sda_raw_i(sda_i),
    .out(bus.sync)
  );

  assign rise = bus.scl & ~r.scl_q;
  assign fall = ~bus.scl & r.scl_q;
  assign start_c = bus.scl & r.scl_q & r.sda_q & ~bus.sda;
  assign stop_c = bus.scl & r.scl_q & ~r.sda_q & bus.sda;

  // Register read map; unmapped offsets read as zero.
  assign rd_data =
    (r.ptr == OFS_PG_LO) ? r.pg[7:0] :
    (r.ptr == OFS_PG_HI) ? {2'h0, r.pg[RAIL_COUNT-1:HI_BASE]} :
    (r.ptr == OFS_FLT_LO) ? r.flt_lo :
    (r.ptr == OFS_FLT_HI) ? {3'h0, r.flt_hi} :
    UNMAPPED_RD;

  always_comb begin
    n = r;
    load_tx = 1'b0;
    wr_en = 1'b0;
    clr_lo = '0;
    clr_hi = '0;
    n.scl_q = bus.scl;
    n.sda_q = bus.sda;
    n.lvl = 1'b0;
    n.pg = bus.ok;
    case (r.st)
      ST_IDLE: begin
        n.oe = 1'b0;
      end
      ST_ADDR, ST_PTR, ST_WR: begin
        if (rise) begin
          n.sh = {r.sh[6:0], bus.sda};
          n.cnt = r.cnt + 4'h1;
        end else if (fall && r.cnt == BYTE_BITS) begin
          n.oe = 1'b1;
          if (r.st == ST_ADDR) begin
            n.rw = r.sh[0];
            n.st = ST_ACK_A;
            if (r.sh[7:1] != DEV_ADDR) begin
              n.oe = 1'b0;
              n.st = ST_IDLE;
            end
          end else if (r.st == ST_PTR) begin
            n.ptr = r.sh;
            n.st = ST_ACK_P;
          end else begin
            wr_en = 1'b1;
            n.ptr = r.ptr + 8'h01;
            n.st = ST_ACK_W;
          end
        end
      end
      ST_ACK_A, ST_ACK_P, ST_ACK_W: begin
        if (fall) begin
          n.cnt = '0;
          n.oe = 1'b0;
          n.st = ST_WR;
          if (r.st == ST_ACK_A) begin
            n.st = ST_PTR;
          end
          if (r.st == ST_ACK_A && r.rw) begin
            load_tx = 1'b1;
          end
        end
      end
      ST_TX: begin
        if (fall) begin
          if (r.cnt == LAST_BIT) begin
            n.oe = 1'b0;
            n.st = ST_MACK;
          end else begin
            n.cnt = r.cnt + 4'h1;
            n.tx = {r.tx[6:0], 1'b0};
            n.oe = ~r.tx[6];
          end
        end
      end
      ST_MACK: begin
        if (rise && bus.sda) begin
          n.st = ST_IDLE;
        end else if (fall) begin
          load_tx = 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.oe = 1'b0;
      end
    endcase
    if (load_tx) begin
      n.tx = rd_data;
      n.ptr = r.ptr + 8'h01;
      n.cnt = '0;
      n.oe = ~rd_data[7];
      n.st = ST_TX;
    end
    // Only ones written to fault registers clear; all else is ignored.
    if (wr_en && r.ptr == OFS_FLT_LO) begin
      clr_lo = r.sh;
    end
    if (wr_en && r.ptr == OFS_FLT_HI) begin
      clr_hi = r.sh[FLT_HI_W-1:0];
    end
    // A new loss of regulation wins over a clear in the same cycle.
    n.flt_lo = (r.flt_lo & ~clr_lo) | bus.lost[7:0];
    n.flt_hi = (r.flt_hi & ~clr_hi)
      | bus.lost[HI_BASE+FLT_HI_W-1:HI_BASE];
    if (start_c) begin
      n.st = ST_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
    end else if (stop_c) begin
      n.st = ST_IDLE;
      n.oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r <= '{st: ST_IDLE, default: '0};
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign sda_o = r.lvl;
  assign sda_oe_o = r.oe;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  sequence seq_fault_held(b);
    b ##1 b;
  endsequence

  sequence seq_ce_run;
    ce_i ##1 ce_i ##1 ce_i;
  endsequence

  AST_PG_FOLLOWS: assert property (
    ce_i |=> r.pg == $past(bus.ok))
    else $error("power-good bits do not follow regulation state");
  AST_PG_LO_MAP: assert property (
    load_tx && r.ptr == OFS_PG_LO && ce_i |=> r.tx == $past(r.pg[7:0]))
    else $error("low power-good register mapped wrongly");
  AST_PG_RESET: assert property (
    @(posedge clk_sys_i) disable iff (1'b0) !nrst_i |=> r.pg == '0)
    else $error("power-good bits not zero after reset");
  AST_PG_HI_MAP: assert property (
    load_tx && r.ptr == OFS_PG_HI && ce_i |=> r.tx[7:6] == 2'h0
      && r.tx[5:0] == $past(r.pg[RAIL_COUNT-1:HI_BASE]))
    else $error("high power-good register mapped wrongly");
  AST_TERM_GOOD: assert property (
    seq_ce_run |=> r.pg[RAIL_TERM]
      == $past(rail_in_regulation_flag_i[RAIL_TERM], 3))
    else $error("termination good bit does not track its window");
  AST_FLT_STICKY: assert property (
    ce_i && bus.lost[RAIL_BUCK1]
      ##1 !(wr_en && r.ptr == OFS_FLT_LO && r.sh[0])
      |-> seq_fault_held(r.flt_lo[RAIL_BUCK1]))
    else $error("fault bit not latched and held");
  AST_FLT_KEEP: assert property (
    r.flt_lo[RAIL_BUCK6] && !(wr_en && r.ptr == OFS_FLT_LO && r.sh[5])
      |=> r.flt_lo[RAIL_BUCK6])
    else $error("fault bit dropped without a clear");
  AST_FLT_LO_MAP: assert property (
    ce_i && bus.lost[RAIL_LDOA2] |=> r.flt_lo[7])
    else $error("low fault register mapped wrongly");
  AST_FLT_HI_RSVD: assert property (
    load_tx && r.ptr == OFS_FLT_HI && ce_i |=> r.tx[7:5] == 3'h0)
    else $error("reserved fault bits not zero");
  AST_FLT_RESET: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    !nrst_i |=> r.flt_lo == '0 && r.flt_hi == '0)
    else $error("fault bits not zero after reset");
  AST_TERM_FAULT: assert property (
    ce_i && bus.lost[RAIL_TERM] |=> r.flt_hi[3])
    else $error("termination loss not latched");
  AST_ZERO_WRITE: assert property (
    ce_i && wr_en && r.ptr == OFS_FLT_HI && r.sh[3] == 1'b0
      && r.flt_hi[3] |=> r.flt_hi[3])
    else $error("zero write cleared a fault bit");

endmodule : rail_power_status_flags

// file: src/rail_status_pkg.sv
package rail_status_pkg;

  localparam int RAIL_COUNT = 14;
  localparam int SYNC_W = RAIL_COUNT * 2 + 2;

  // Rail positions in the status vectors; the low eight form the low registers.
  localparam int RAIL_BUCK1 = 0;
  localparam int RAIL_BUCK6 = 5;
  localparam int RAIL_SWA1 = 6;
  localparam int RAIL_LDOA2 = 7;
  localparam int RAIL_LDOA3 = 8;
  localparam int RAIL_SWB1 = 9;
  localparam int RAIL_SWB2 = 10;
  localparam int RAIL_TERM = 11;
  localparam int RAIL_LDOA1 = 12;
  localparam int RAIL_LDO5 = 13;
  localparam int HI_BASE = 8;
  localparam int PG_HI_W = 6;
  localparam int FLT_HI_W = 5;

  localparam logic [7:0] OFS_PG_LO = 8'hB0;
  localparam logic [7:0] OFS_PG_HI = 8'hB1;
  localparam logic [7:0] OFS_FLT_LO = 8'hB2;
  localparam logic [7:0] OFS_FLT_HI = 8'hB3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Serial target address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h5E;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACK_A = 9'h004,
    ST_PTR = 9'h008,
    ST_ACK_P = 9'h010,
    ST_WR = 9'h020,
    ST_ACK_W = 9'h040,
    ST_TX = 9'h080,
    ST_MACK = 9'h100
  } serial_state_t;

  typedef struct packed {
    serial_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic oe;
    logic lvl;
    logic [RAIL_COUNT-1:0] pg;
    logic [7:0] flt_lo;
    logic [FLT_HI_W-1:0] flt_hi;
  } bank_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } sync_state_t;

endpackage : rail_status_pkg

// file: src/rail_status_if.sv
`timescale 1ns/1ps
interface rail_status_if;
  import rail_status_pkg::*;
  logic [RAIL_COUNT-1:0] ok;
  logic [RAIL_COUNT-1:0] lost;
  logic scl;
  logic sda;
  modport sync (output ok, output lost, output scl, output sda);
  modport bank (input ok, input lost, input scl, input sda);
endinterface : rail_status_if

// file: src/rail_input_sync.sv
`timescale 1ns/1ps
module rail_input_sync
  import rail_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [RAIL_COUNT-1:0] ok_raw_i,
  input wire logic [RAIL_COUNT-1:0] lost_raw_i,
  input wire logic scl_raw_i,
  input wire logic sda_raw_i,
  rail_status_if.sync out
);
  sync_state_t r;
  sync_state_t n;
  logic [SYNC_W-1:0] raw;

  assign raw = {sda_raw_i, scl_raw_i, lost_raw_i, ok_raw_i};

  // Each bit passes two flops; only the second one is read.
  always_comb begin
    n = r;
    for (int i = 0; i < SYNC_W; i++) begin
      n.s1[i] = raw[i];
      n.s2[i] = r.s1[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign out.ok = r.s2[RAIL_COUNT-1:0];
  assign out.lost = r.s2[2*RAIL_COUNT-1:RAIL_COUNT];
  assign out.scl = r.s2[SYNC_W-2];
  assign out.sda = r.s2[SYNC_W-1];

endmodule : rail_input_sync

// file: dv/rail_host.sv
`timescale 1ns/1ps
// Serial controller that reads and clears the status bank.
module rail_host (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
  end
  task automatic w4();
    repeat (4) @(negedge clk_sys_i);
  endtask : w4
  // Serves as START and as repeated START.
  task automatic start_bus();
    @(negedge clk_sys_i);
    scl_o = 1'h0;
    w4();
    sda_low_o = 1'h0;
    w4();
    scl_o = 1'h1;
    w4();
    sda_low_o = 1'h1;
    w4();
  endtask : start_bus
  task automatic stop_bus();
    scl_o = 1'h0;
    w4();
    sda_low_o = 1'h1;
    w4();
    scl_o = 1'h1;
    w4();
    sda_low_o = 1'h0;
    w4();
  endtask : stop_bus
  // Data changes only while the clock line is low.
  task automatic bit_io(input logic b, output logic r);
    scl_o = 1'h0;
    w4();
    sda_low_o = ~b;
    w4();
    scl_o = 1'h1;
    w4();
    r = sda_i;
    w4();
  endtask : bit_io
  // Writing ones to a fault register is how the host clears it.
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ack = (r === 1'h0);
  endtask : send_byte
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask : recv_byte
endmodule : rail_host

// file: dv/rail_power_status_flags_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  mismatches++; $display("FAIL %0t got %h exp %h", $time, got, exp); end end
module rail_power_status_flags_bench
  import rail_status_pkg::*;
;
  logic clk_sys_i = 1'h0;
  logic nrst_i = 1'h0;
  logic ce_v = 1'h1;
  logic [RAIL_COUNT-1:0] ok_v = '0;
  logic [RAIL_COUNT-1:0] lost_v = '0;
  logic scl, sda_low, sda_o, sda_oe_o, a;
  wire sda_line = ~sda_low & (~sda_oe_o | sda_o);
  int mismatches = 0;
  int checked = 0;
  logic [7:0] rd [4];
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  rail_power_status_flags u_rail_power_status_flags (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_v),
    .rail_in_regulation_flag_i(ok_v), .rail_regulation_lost_flag_i(lost_v),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  rail_host u_rail_host (.clk_sys_i(clk_sys_i), .sda_i(sda_line),
    .scl_o(scl), .sda_low_o(sda_low));
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Reads four registers in one burst, starting at the given offset.
  task automatic rd_regs(input logic [7:0] ofs);
    u_rail_host.start_bus();
    u_rail_host.send_byte({DEV_ADDR, 1'h0}, a);
    u_rail_host.send_byte(ofs, a);
    u_rail_host.start_bus();
    u_rail_host.send_byte({DEV_ADDR, 1'h1}, a);
    `CHK(a, 1'h1)
    for (int i = 0; i < 4; i++) begin
      u_rail_host.recv_byte(i < 3, rd[i]);
    end
    u_rail_host.stop_bus();
  endtask : rd_regs
  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
    u_rail_host.start_bus();
    u_rail_host.send_byte({DEV_ADDR, 1'h0}, a);
    u_rail_host.send_byte(ofs, a);
    u_rail_host.send_byte(d, a);
    `CHK(a, 1'h1)
    u_rail_host.stop_bus();
  endtask : wr_reg
  task automatic pulse(input logic [RAIL_COUNT-1:0] p);
    lost_v = p;
    repeat (4) @(negedge clk_sys_i);
    lost_v = '0;
  endtask : pulse
  task automatic t_reset();
    rd_regs(OFS_PG_LO);
    `CHK({rd[0], rd[1]}, 16'h0000)
    `CHK({rd[2], rd[3]}, 16'h0000)
  endtask : t_reset
  task automatic t_good();
    logic [RAIL_COUNT-1:0] pats [2] = '{14'h15A5, 14'h2A5A};
    foreach (pats[k]) begin
      ok_v = pats[k];
      rd_regs(OFS_PG_LO);
      `CHK(rd[0], pats[k][7:0])
      `CHK(rd[1], {2'h0, pats[k][13:8]})
      `CHK(rd[1][3], pats[k][RAIL_TERM])
      `CHK({rd[2], rd[3]}, 16'h0000)
    end
  endtask : t_good
  task automatic t_fault();
    ok_v = '1;
    pulse(14'h0A5A);
    rd_regs(OFS_PG_LO);
    `CHK(rd[2], 8'h5A)
    `CHK(rd[3], 8'h0A)
    `CHK(rd[1], 8'h3F)
    pulse(14'h35A5);
    rd_regs(OFS_PG_LO);
    `CHK({rd[2], rd[3]}, 16'hFF1F)
  endtask : t_fault
  task automatic t_clear();
    wr_reg(OFS_FLT_LO, 8'h00);
    wr_reg(OFS_FLT_HI, 8'h00);
    wr_reg(OFS_PG_LO, 8'hFF);
    wr_reg(OFS_PG_HI, 8'hFF);
    rd_regs(OFS_PG_LO);
    `CHK({rd[0], rd[1], rd[2], rd[3]}, 32'hFF3FFF1F)
    wr_reg(OFS_FLT_LO, 8'h0F);
    wr_reg(OFS_FLT_HI, 8'hE8);
    rd_regs(OFS_PG_LO);
    `CHK(rd[2], 8'hF0)
    `CHK(rd[3], 8'h17)
    lost_v[RAIL_TERM] = 1'h1;
    wr_reg(OFS_FLT_HI, 8'h1F);
    rd_regs(OFS_FLT_HI);
    `CHK(rd[0], 8'h08)
    lost_v = '0;
    wr_reg(OFS_FLT_HI, 8'h08);
    wr_reg(OFS_FLT_LO, 8'hF0);
    rd_regs(OFS_FLT_LO);
    `CHK({rd[0], rd[1]}, 16'h0000)
  endtask : t_clear
  // Losses seen with the enable low are lost; a mid-run reset clears faults.
  task automatic t_hold();
    ce_v = 1'h0;
    pulse(14'h0101);
    ce_v = 1'h1;
    rd_regs(OFS_FLT_LO);
    `CHK({rd[0], rd[1]}, 16'h0000)
    pulse(14'h1FFF);
    rd_regs(OFS_FLT_LO);
    `CHK({rd[0], rd[1]}, 16'hFF1F)
    nrst_i = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    rd_regs(OFS_PG_LO);
    `CHK({rd[0], rd[1]}, 16'hFF3F)
    `CHK({rd[2], rd[3]}, 16'h0000)
  endtask : t_hold
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    nrst_i = 1'h1;
    repeat (3) @(negedge clk_sys_i);
    t_reset();
    t_good();
    t_fault();
    t_clear();
    t_hold();
    print_verdict();
  end
endmodule : rail_power_status_flags_bench
